// ==== logic/ptc_channel_ctrl.sv ====
// Our own choice: the plain strobed port.
`include "ptc_defs.svh"

module ptc_channel_ctrl
	import ptc_pkg::*;
#(
	parameter int NCH = `PTC_NUM_CH
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_sys_rst,
	input  wire logic [7:0]       i_addr,
	input  wire logic [7:0]       i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output logic      [7:0]       o_rdata,
	output logic      [NCH-1:0]   o_ch_irq,
	output logic      [NCH-1:0]   o_periodic_trigger_out,
	output logic      [NCH*16-1:0] o_count,
	output logic                  o_irq
);

	ptc_bus_req_s req;
	logic         module_on_bit;
	logic [NCH-1:0] channel_run_bits;
	logic [NCH-1:0] timebase_select_bits;
	logic [NCH-1:0] timeout_irq_enable_bits;
	logic [NCH-1:0] timeout_flag_bits;
	logic [7:0]   micro_reload_value [2];
	logic [7:0]   micro_cnt [2];
	logic [1:0]   micro_active;
	logic [1:0]   micro_zero;
	logic [1:0]   micro_force_reload_strobes;
	ptc_count_t   channel_reload_register [NCH];
	ptc_count_t   ch_cnt [NCH];
	logic [1:0]   ch_sel;
	logic [7:0]   reload_lo_hold;
	logic [NCH-1:0] force_ch;
	logic [NCH-1:0] ch_live;
	logic [NCH-1:0] ch_start;
	logic [NCH-1:0] timeout;
	logic [NCH-1:0] prev_live;
	logic [NCH-1:0] going_off;
	logic [NCH-1:0] evt_status;
	logic [NCH-1:0] evt_mask;

	// decode of a write to one offset
	function automatic logic wr_hit(input ptc_bus_req_s r, input logic [7:0] off);
		wr_hit = r.wr && (r.addr == off);
	endfunction

	// decode of a read from one offset
	function automatic logic rd_hit(input ptc_bus_req_s r, input logic [7:0] off);
		rd_hit = r.rd && (r.addr == off);
	endfunction

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// channel running only when module on and run bit set
	assign ch_live = module_on_bit ? channel_run_bits : '0;
	assign ch_start = ch_live & ~prev_live;

	// channels switched off by the write of this very cycle;
	// clearing the flag at that edge means a read straight after
	// the write never sees a stale flag, and the request drops
	// one cycle earlier than it would from the registered run bits
	always_comb begin
		going_off = '0;
		if (wr_hit(req, `PTC_OFF_CONTROL) && !req.wdata[`PTC_BIT_MODULE_ON])
			going_off = '1;
		if (wr_hit(req, `PTC_OFF_CH_ENABLE))
			going_off = going_off | ~req.wdata[NCH-1:0];
	end

	// micro timer runs while any live channel selects it
	always_comb begin
		micro_active = 2'b00;
		for (int c = 0; c < NCH; c++) begin
			if (ch_live[c]) begin
				micro_active[timebase_select_bits[c]] = 1'b1;
			end
		end
	end

	// control and force strobes
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			module_on_bit <= 1'b0;
			micro_force_reload_strobes <= 2'b00;
		end else begin
			micro_force_reload_strobes <= 2'b00;
			if (wr_hit(req, `PTC_OFF_CONTROL)) begin
				module_on_bit <= req.wdata[`PTC_BIT_MODULE_ON];
				micro_force_reload_strobes <= req.wdata[1:0];
			end
		end
	end

	// configuration registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			channel_run_bits <= '0;
			timebase_select_bits <= '0;
			timeout_irq_enable_bits <= '0;
			micro_reload_value[0] <= `PTC_RST_BYTE;
			micro_reload_value[1] <= `PTC_RST_BYTE;
			ch_sel <= 2'b00;
		end else begin
			if (wr_hit(req, `PTC_OFF_CH_ENABLE))
				channel_run_bits <= req.wdata[NCH-1:0];
			if (wr_hit(req, `PTC_OFF_TB_SELECT))
				timebase_select_bits <= req.wdata[NCH-1:0];
			if (wr_hit(req, `PTC_OFF_IRQ_ENABLE))
				timeout_irq_enable_bits <= req.wdata[NCH-1:0];
			if (wr_hit(req, `PTC_OFF_MRELOAD0))
				micro_reload_value[0] <= req.wdata;
			if (wr_hit(req, `PTC_OFF_MRELOAD1))
				micro_reload_value[1] <= req.wdata;
			if (wr_hit(req, `PTC_OFF_CH_SELECT))
				ch_sel <= req.wdata[1:0];
		end
	end

	// channel reload register, low byte held until high byte write
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			reload_lo_hold <= `PTC_RST_BYTE;
			for (int c = 0; c < NCH; c++)
				channel_reload_register[c] <= `PTC_RST_RELOAD16;
		end else begin
			if (wr_hit(req, `PTC_OFF_CH_RELOAD_LO))
				reload_lo_hold <= req.wdata;
			if (wr_hit(req, `PTC_OFF_CH_RELOAD_HI))
				channel_reload_register[ch_sel] <= {req.wdata, reload_lo_hold};
		end
	end

	// channel force-load strobes, effective only on live channels
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			force_ch <= '0;
		else if (wr_hit(req, `PTC_OFF_FORCE_CH))
			force_ch <= req.wdata[NCH-1:0] & ch_live;
		else
			force_ch <= '0;
	end

	// micro time base down-counters
	generate
		for (genvar m = 0; m < 2; m++) begin : g_micro
			assign micro_zero[m] = micro_active[m] && (micro_cnt[m] == 8'h00);
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					micro_cnt[m] <= `PTC_RST_BYTE;
				end else if (!micro_active[m]) begin
					micro_cnt[m] <= micro_reload_value[m]; // start value on first select
				end else if (micro_force_reload_strobes[m]) begin
					micro_cnt[m] <= micro_reload_value[m];
				end else if (micro_cnt[m] == 8'h00) begin
					micro_cnt[m] <= micro_reload_value[m];
				end else begin
					micro_cnt[m] <= micro_cnt[m] - 8'h01;
				end
			end
		end
	endgenerate

	// 16-bit channel counters, flags and triggers
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			// tick from the currently selected base, switched at once
			assign timeout[c] = ch_live[c] && !ch_start[c] && !force_ch[c]
				&& micro_zero[timebase_select_bits[c]] && (ch_cnt[c] == 16'h0000);

			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					ch_cnt[c] <= `PTC_RST_RELOAD16;
				end else if (ch_start[c] || force_ch[c]) begin
					ch_cnt[c] <= channel_reload_register[c];
				end else if (ch_live[c] && micro_zero[timebase_select_bits[c]]) begin
					if (ch_cnt[c] == 16'h0000)
						ch_cnt[c] <= channel_reload_register[c];
					else
						ch_cnt[c] <= ch_cnt[c] - 16'h0001;
				end
			end

			// flag: set wins over clear, forced low when channel not live
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst)
					timeout_flag_bits[c] <= 1'b0;
				else if (!ch_live[c] || going_off[c])
					timeout_flag_bits[c] <= 1'b0;
				else if (timeout[c])
					timeout_flag_bits[c] <= 1'b1;
				else if (wr_hit(req, `PTC_OFF_FLAGS) && req.wdata[c])
					timeout_flag_bits[c] <= 1'b0;
			end

			// trigger high for one cycle per time-out
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst)
					o_periodic_trigger_out[c] <= 1'b0;
				else
					o_periodic_trigger_out[c] <= timeout[c];
			end

			// request level, registered
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst)
					o_ch_irq[c] <= 1'b0;
				else
					o_ch_irq[c] <= timeout_flag_bits[c] & timeout_irq_enable_bits[c];
			end

			assign o_count[c*16 +: 16] = ch_cnt[c];
		end
	endgenerate

	// previous live state for start detection
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			prev_live <= '0;
		else
			prev_live <= ch_live;
	end

	// sticky event status, cleared by a read, set wins
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			evt_status <= '0;
		else if (rd_hit(req, `PTC_OFF_EVT_STATUS))
			evt_status <= timeout;
		else
			evt_status <= evt_status | timeout;
	end

	// event mask
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			evt_mask <= '0;
		else if (wr_hit(req, `PTC_OFF_EVT_MASK))
			evt_mask <= req.wdata[NCH-1:0];
	end

	// summary interrupt level
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |((evt_status | timeout) & evt_mask);
	end

	// read data, one cycle after the strobe
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`PTC_OFF_CONTROL:      o_rdata <= {module_on_bit, 7'h00};
				`PTC_OFF_CH_ENABLE:    o_rdata <= 8'(channel_run_bits);
				`PTC_OFF_TB_SELECT:    o_rdata <= 8'(timebase_select_bits);
				`PTC_OFF_IRQ_ENABLE:   o_rdata <= 8'(timeout_irq_enable_bits);
				`PTC_OFF_FLAGS:        o_rdata <= 8'(timeout_flag_bits);
				`PTC_OFF_MRELOAD0:     o_rdata <= micro_reload_value[0];
				`PTC_OFF_MRELOAD1:     o_rdata <= micro_reload_value[1];
				`PTC_OFF_CH_RELOAD_LO: o_rdata <= channel_reload_register[ch_sel][7:0];
				`PTC_OFF_CH_RELOAD_HI: o_rdata <= channel_reload_register[ch_sel][15:8];
				`PTC_OFF_CH_SELECT:    o_rdata <= {6'h00, ch_sel};
				`PTC_OFF_EVT_STATUS:   o_rdata <= 8'(evt_status);
				`PTC_OFF_EVT_MASK:     o_rdata <= 8'(evt_mask);
				default:               o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule

// ==== shared/ptc_defs.svh ====
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// register offsets
`define PTC_OFF_CONTROL       8'h00
`define PTC_OFF_CH_ENABLE     8'h02
`define PTC_OFF_TB_SELECT     8'h03
`define PTC_OFF_IRQ_ENABLE    8'h04
`define PTC_OFF_FLAGS         8'h05
`define PTC_OFF_MRELOAD0      8'h06
`define PTC_OFF_MRELOAD1      8'h07
`define PTC_OFF_CH_RELOAD_LO  8'h08
`define PTC_OFF_CH_RELOAD_HI  8'h09
`define PTC_OFF_CH_SELECT     8'h0A
`define PTC_OFF_FORCE_CH      8'h0B
`define PTC_OFF_EVT_STATUS    8'h0C
`define PTC_OFF_EVT_MASK      8'h0D

// field positions and counts
`define PTC_BIT_MODULE_ON     7
`define PTC_NUM_CH            4
`define PTC_NUM_MT            2

// reset values
`define PTC_RST_BYTE          8'h00
`define PTC_RST_RELOAD16      16'h0000

`endif

// ==== shared/ptc_pkg.sv ====
package ptc_pkg;
	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ptc_bus_req_s;

	// per channel reload value
	typedef logic [15:0] ptc_count_t;
endpackage

// ==== verification/ptc_channel_ctrl_assertions.sv ====
module ptc_channel_ctrl_assertions #(
	parameter int NCH = 4
) (
	input wire logic               i_clk_sys,
	input wire logic               i_sys_rst,
	input wire logic [7:0]         i_addr,
	input wire logic [7:0]         i_wdata,
	input wire logic               i_wr,
	input wire logic               i_rd,
	input wire logic [7:0]         o_rdata,
	input wire logic [NCH-1:0]     o_ch_irq,
	input wire logic [NCH-1:0]     o_periodic_trigger_out,
	input wire logic [NCH*16-1:0]  o_count,
	input wire logic               o_irq
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// a write strobe at one offset
	sequence s_wr(a);
		i_wr && i_addr == a;
	endsequence
	// clear of flag 0 with no hardware set beside it
	sequence s_clr0;
		s_wr(8'h05) ##1 !o_periodic_trigger_out[0];
	endsequence
	property p_rdata_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	property p_mreload_rb;
		s_wr(8'h06) ##1 (i_rd && i_addr == 8'h06) |=> o_rdata == $past(i_wdata, 2);
	endproperty
	property p_chen_clear;
		s_wr(8'h02) |-> ##2 (o_ch_irq & ~$past(i_wdata[NCH-1:0], 2)) == '0;
	endproperty
	property p_irqen_clear;
		s_wr(8'h04) |-> ##2 (o_ch_irq & ~$past(i_wdata[NCH-1:0], 2)) == '0;
	endproperty
	property p_module_off;
		i_wr && i_addr == 8'h00 && !i_wdata[7] |-> ##2 o_ch_irq == '0;
	endproperty
	property p_w1c;
		s_clr0 |-> (!$past(i_wdata[0])) or (##1 !o_ch_irq[0]);
	endproperty
	property p_irq_cause;
		$rose(o_ch_irq[0]) |-> $past(o_periodic_trigger_out[0]) || $past(i_wr && i_addr == 8'h04, 2);
	endproperty
	property p_trig_zero;
		$rose(o_periodic_trigger_out[0]) |-> $past(o_count[15:0]) == 16'h0000;
	endproperty
	property p_count_step;
		$past(o_count[15:0]) != 16'h0000 && o_count[15:0] != $past(o_count[15:0]) && !$past(i_wr)
			&& !$past(i_wr, 2)
			|-> o_count[15:0] == $past(o_count[15:0]) - 16'h0001;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	a_mreload_rb: assert property (p_mreload_rb) else $error("micro reload readback");
	a_chen_clear: assert property (p_chen_clear) else $error("request of stopped channel");
	a_irqen_clear: assert property (p_irqen_clear) else $error("request while disabled");
	a_module_off: assert property (p_module_off) else $error("request with module off");
	a_w1c: assert property (p_w1c) else $error("flag not cleared by write one");
	a_irq_cause: assert property (p_irq_cause) else $error("request without cause");
	a_trig_zero: assert property (p_trig_zero) else $error("trigger before count zero");
	a_count_step: assert property (p_count_step) else $error("counter step not one");
endmodule

// ==== verification/test_ptc_channel_ctrl.sv ====
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module test_ptc_channel_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk_sys, i_sys_rst, i_wr, i_rd, o_irq;
	logic [7:0]  i_addr, i_wdata, o_rdata;
	logic [3:0]  o_ch_irq, o_periodic_trigger_out;
	logic [63:0] o_count;
	int          bad_count, n_compared, n;
	ptc_channel_ctrl dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ch_irq(o_ch_irq), .o_irq(o_irq),
		.o_periodic_trigger_out(o_periodic_trigger_out), .o_count(o_count));
	// bus clock
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// one write cycle, a gap cycle when writes follow each other
	task automatic wr(input logic [7:0] a, d);
		if (i_wr) @(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	// one read cycle, data judged in the cycle after
	task automatic rd(input logic [7:0] a, e, input string nm);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 `CHK(nm, e, o_rdata)
		@(posedge i_clk_sys);
	endtask
	// cycles until the next trigger of channel 0
	task automatic wait_trig(output int c);
		c = 0;
		do begin
			@(posedge i_clk_sys);
			c++;
		end while (!o_periodic_trigger_out[0] && c < 300);
		`CHK("trigger seen", 1'b1, o_periodic_trigger_out[0])
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic t_regs();
		for (int a = 2; a < 8; a++) rd(8'(a), 8'h00, "reset value");
		wr(8'h06, 8'hA5);
		rd(8'h06, 8'hA5, "micro reload 0");
		wr(8'h07, 8'h5A);
		rd(8'h07, 8'h5A, "micro reload 1");
		wr(8'h05, 8'h0F);
		rd(8'h05, 8'h00, "flags idle");
		rd(8'h1F, 8'h00, "unmapped");
		$display("test regs done");
	endtask
	task automatic t_timeout();
		wr(8'h06, 8'h02);
		wr(8'h0A, 8'h00);
		wr(8'h08, 8'h03);
		wr(8'h09, 8'h00);
		wr(8'h0D, 8'h0F);
		wr(8'h04, 8'h01);
		wr(8'h02, 8'h01);
		wr(8'h00, 8'h80);
		wait_trig(n);
		wait_trig(n);
		`CHK("period", 12, n)
		rd(8'h05, 8'h01, "flag set");
		`CHK("channel irq", 1'b1, o_ch_irq[0])
		`CHK("irq", 1'b1, o_irq)
		wr(8'h05, 8'h00);
		rd(8'h05, 8'h01, "flag kept");
		wr(8'h05, 8'h01);
		rd(8'h05, 8'h00, "flag cleared");
		wr(8'h04, 8'h00);
		wait_trig(n);
		rd(8'h05, 8'h01, "flag again");
		`CHK("masked irq", 1'b0, o_ch_irq[0])
		wr(8'h04, 8'h01);
		repeat (2) @(posedge i_clk_sys);
		`CHK("pending irq", 1'b1, o_ch_irq[0])
		wait_trig(n);
		wr(8'h04, 8'h00);
		wr(8'h05, 8'h01);
		wr(8'h04, 8'h01);
		repeat (2) @(posedge i_clk_sys);
		`CHK("no spurious irq", 1'b0, o_ch_irq[0])
		$display("test timeout done");
	endtask
	task automatic t_select();
		wr(8'h07, 8'h05);
		wr(8'h03, 8'h01);
		wait_trig(n);
		wait_trig(n);
		`CHK("base 1 period", 24, n)
		wr(8'h03, 8'h00);
		wait_trig(n);
		wait_trig(n);
		`CHK("base 0 period", 12, n)
		$display("test select done");
	endtask
	task automatic t_off();
		wr(8'h02, 8'h00);
		rd(8'h05, 8'h00, "channel off flag");
		wr(8'h02, 8'h01);
		repeat (2) @(posedge i_clk_sys);
		`CHK("start count", 16'h0003, o_count[15:0])
		wait_trig(n);
		wr(8'h00, 8'h00);
		rd(8'h05, 8'h00, "module off flag");
		rd(8'h0C, 8'h01, "event status");
		rd(8'h0C, 8'h00, "event status cleared");
		`CHK("irq after status read", 1'b0, o_irq)
		`CHK("idle channels", 48'h0, o_count[63:16])
		$display("test off done");
	endtask
	// watchdog against a hang
	initial begin
		#100us;
		bad_count++;
		print_verdict();
	end
	initial begin
		{i_wr, i_rd, i_addr, i_wdata} = '0;
		i_sys_rst = 1'b1;
		repeat (4) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		t_regs();
		t_timeout();
		t_select();
		t_off();
		print_verdict();
	end
endmodule
bind ptc_channel_ctrl ptc_channel_ctrl_assertions #(.NCH(NCH)) u_chk (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_ch_irq(o_ch_irq), .o_periodic_trigger_out(o_periodic_trigger_out),
	.o_count(o_count), .o_irq(o_irq));
